// [pkg/ccie_pkg.sv]
package ccie_pkg;
	localparam int CCIE_INSTR_W = 14;
	localparam int CCIE_PC_W = 13;
	localparam int CCIE_FADDR_W = 7;
	localparam int CCIE_DATA_W = 8;
	localparam int CCIE_IMM_W = 11;
	localparam logic [5:0] CCIE_OP_CLR_HI = 6'h01;
	localparam int CCIE_CLR_SEL_BIT = 7;
	localparam logic [2:0] CCIE_OP_CALL_HI = 3'h4;
	localparam int CCIE_LATH_HI_POS = 4;
	localparam int CCIE_LATH_LO_POS = 3;
	localparam logic [7:0] CCIE_ZERO_DATA = 8'h00;
	localparam logic [12:0] CCIE_PC_RESET = 13'h0000;
	localparam logic [12:0] CCIE_PC_STEP = 13'h0001;
	localparam int CCIE_CALL_CYCLES = 2;
	typedef enum logic [1:0] {
		CCIE_OP_NONE,
		CCIE_OP_CLR_FILE,
		CCIE_OP_CLR_ACC,
		CCIE_OP_CALL
	} ccie_op_e;
endpackage : ccie_pkg

// [core/ccie_decode.sv]
`timescale 1ns/1ps
module ccie_decode
	import ccie_pkg::*;
(
	input wire logic [CCIE_INSTR_W-1:0] instr_in,
	output ccie_op_e op_out
);
	always_comb
	begin
		op_out = CCIE_OP_NONE;
		if (instr_in[13:11] == CCIE_OP_CALL_HI)
			op_out = CCIE_OP_CALL;
		else if (instr_in[13:8] == CCIE_OP_CLR_HI)
			// low seven bits ignored for accumulator clear
			op_out = instr_in[CCIE_CLR_SEL_BIT] ? CCIE_OP_CLR_FILE : CCIE_OP_CLR_ACC; // RULE7
	end
endmodule : ccie_decode

// [core/ccie_exec.sv]
`timescale 1ns/1ps
// Functional notes
// (RULE1) file clear writes zero to the addressed register and sets zero flag.
// (RULE2) call pushes current pc plus one onto the stack top entry first.
// (RULE3) call loads its 11-bit immediate into pc bits 10 to 0.
// (RULE4) call takes pc bits 12 and 11 from latch bits 4 and 3.
// (RULE5) call spends two instruction cycles while being a single word.
// (RULE6) accumulator clear writes zero to the accumulator and sets zero flag.
// (RULE7) clears take one cycle; accumulator clear ignores low bits; call keeps flags.
module ccie_exec
	import ccie_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic instr_valid_in,
	input wire logic [CCIE_INSTR_W-1:0] instr_in,
	input wire logic [CCIE_DATA_W-1:0] program_counter_high_latch_in,
	output logic instr_ready_out,
	output logic [CCIE_PC_W-1:0] pc_out,
	output logic file_wr_en_out,
	output logic [CCIE_FADDR_W-1:0] file_wr_addr_out,
	output logic [CCIE_DATA_W-1:0] file_wr_data_out,
	output logic acc_wr_en_out,
	output logic [CCIE_DATA_W-1:0] acc_wr_data_out,
	output logic zero_flag_set_out,
	output logic stack_push_out,
	output logic [CCIE_PC_W-1:0] stack_top_entry_out,
	output logic flush_out
);
	typedef enum logic {CCIE_ST_RUN, CCIE_ST_CALL2} ccie_state_e;
	typedef struct packed {
		ccie_state_e st;
		logic [CCIE_PC_W-1:0] pc;
		logic fwe;
		logic [CCIE_FADDR_W-1:0] fa;
		logic awe;
		logic zset;
		logic push;
		logic [CCIE_PC_W-1:0] stack_top_entry;
		logic flush;
	} ccie_state_s;

	ccie_state_s cur;
	ccie_state_s next_cur;
	ccie_op_e op;

	ccie_decode u_decode (
		.instr_in(instr_in),
		.op_out(op)
	);

	// second call cycle executes a discarded fetch, so no new instruction
	assign instr_ready_out = (cur.st == CCIE_ST_RUN);

	always_comb
	begin
		next_cur = cur;
		next_cur.fwe = 1'b0;
		next_cur.awe = 1'b0;
		next_cur.zset = 1'b0;
		next_cur.push = 1'b0;
		next_cur.flush = 1'b0;
		unique case (cur.st)
			CCIE_ST_RUN:
			begin
				if (instr_valid_in)
				begin
					next_cur.pc = cur.pc + CCIE_PC_STEP;
					unique case (op)
						CCIE_OP_CLR_FILE:
						begin
							next_cur.fwe = 1'b1; // RULE1
							next_cur.fa = instr_in[CCIE_FADDR_W-1:0];
							next_cur.zset = 1'b1; // RULE1
						end
						CCIE_OP_CLR_ACC:
						begin
							next_cur.awe = 1'b1; // RULE6
							next_cur.zset = 1'b1; // RULE6
						end
						CCIE_OP_CALL:
						begin
							next_cur.push = 1'b1; // RULE2
							next_cur.stack_top_entry = cur.pc + CCIE_PC_STEP; // RULE2
							next_cur.pc = {program_counter_high_latch_in[CCIE_LATH_HI_POS:
								CCIE_LATH_LO_POS], instr_in[CCIE_IMM_W-1:0]}; // RULE3 RULE4
							next_cur.flush = 1'b1; // RULE5
							next_cur.st = CCIE_ST_CALL2; // RULE5
						end
						CCIE_OP_NONE:
						begin
						end
					endcase
				end
			end
			CCIE_ST_CALL2:
				next_cur.st = CCIE_ST_RUN; // RULE5
		endcase
	end

	always_ff @(posedge core_clk_in)
	begin
		if (!rst_b_in)
		begin
			cur <= '0;
			cur.st <= CCIE_ST_RUN;
			cur.pc <= CCIE_PC_RESET;
		end
		else
			cur <= next_cur;
	end

	assign pc_out = cur.pc;
	assign file_wr_en_out = cur.fwe;
	assign file_wr_addr_out = cur.fa;
	assign file_wr_data_out = CCIE_ZERO_DATA;
	assign acc_wr_en_out = cur.awe;
	assign acc_wr_data_out = CCIE_ZERO_DATA;
	assign zero_flag_set_out = cur.zset;
	assign stack_push_out = cur.push;
	assign stack_top_entry_out = cur.stack_top_entry;
	assign flush_out = cur.flush;

	// call taken at this edge; every push must trace back to one of these
	logic call_take;
	assign call_take = instr_valid_in && instr_ready_out && op == CCIE_OP_CALL;

	sequence s_call_issue;
		instr_valid_in && instr_ready_out && op == CCIE_OP_CALL;
	endsequence
	sequence s_call_tail;
		!instr_ready_out ##1 instr_ready_out;
	endsequence
	// raw opcode fields, so a broken decoder cannot hide behind op
	sequence s_clear_file_reg_op_word;
		instr_valid_in && instr_ready_out && instr_in[13:7] == {CCIE_OP_CLR_HI, 1'b1};
	endsequence
	sequence s_clear_accumulator_op_word;
		instr_valid_in && instr_ready_out && instr_in[13:7] == {CCIE_OP_CLR_HI, 1'b0};
	endsequence
	sequence s_call_word;
		instr_valid_in && instr_ready_out && instr_in[13:11] == CCIE_OP_CALL_HI;
	endsequence
	// second call cycle: fetched word dropped, nothing written, pc parked
	sequence s_call2_quiet;
		$stable(pc_out) && !stack_push_out && !file_wr_en_out && !acc_wr_en_out
			&& !zero_flag_set_out;
	endsequence

	AST_CLEAR_FILE_REG_OP_ZERO: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE1
		instr_valid_in && instr_ready_out && op == CCIE_OP_CLR_FILE |=>
		file_wr_en_out && zero_flag_set_out && file_wr_addr_out == $past(instr_in[6:0]))
		else $error("file clear did not write zero and set flag");
	AST_CALL_PUSH: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE2
		s_call_issue |=> stack_push_out && stack_top_entry_out == $past(pc_out) + 13'h0001)
		else $error("call pushed wrong return address");
	AST_CALL_LOW: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE3
		s_call_issue |=> pc_out[10:0] == $past(instr_in[10:0]))
		else $error("call low pc bits wrong");
	AST_CALL_HIGH: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE4
		s_call_issue |=> pc_out[12:11] == $past(program_counter_high_latch_in[4:3]))
		else $error("call high pc bits wrong");
	AST_CALL_TWO: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE5
		s_call_issue |=> s_call_tail)
		else $error("call did not take two cycles");
	AST_CLEAR_ACCUMULATOR_OP_ZERO: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE6
		instr_valid_in && instr_ready_out && op == CCIE_OP_CLR_ACC |=>
		acc_wr_en_out && zero_flag_set_out && !file_wr_en_out)
		else $error("accumulator clear wrong");
	AST_CLR_ONE: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE7
		instr_valid_in && instr_ready_out && op inside {CCIE_OP_CLR_FILE, CCIE_OP_CLR_ACC}
		|=> instr_ready_out && pc_out == $past(pc_out) + 13'h0001)
		else $error("clear took more than one cycle");
	AST_CALL_FLAGS: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE7
		s_call_issue |=> !zero_flag_set_out ##1 !zero_flag_set_out)
		else $error("call touched status flag");

	// stack and write ports only move for their own instruction
	AST_CALL_FLUSH: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE5
		s_call_issue |=> flush_out && !file_wr_en_out && !acc_wr_en_out)
		else $error("call did not drop the fetched word");
	AST_CALL_SPAN: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE5
		s_call_issue |-> ##CCIE_CALL_CYCLES instr_ready_out)
		else $error("call not finished after its cycle count");
	AST_CALL2_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE5
		!instr_ready_out |=> s_call2_quiet)
		else $error("second call cycle executed an instruction");
	AST_PUSH_SRC: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE2
		stack_push_out |-> $past(call_take))
		else $error("push without a call");
	AST_PUSH_ONCE: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE2
		stack_push_out |=> !stack_push_out)
		else $error("one call pushed twice");
	AST_TOS_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE2
		!stack_push_out |-> $stable(stack_top_entry_out))
		else $error("stack top entry moved without a push");
	AST_ADDR_HOLD: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE1
		!file_wr_en_out |-> $stable(file_wr_addr_out))
		else $error("file address moved without a write");
	AST_ZSET_SRC: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE7
		zero_flag_set_out |-> file_wr_en_out || acc_wr_en_out)
		else $error("zero flag set by something other than a clear");

	// same duties keyed on raw instruction bits; low bits of accumulator clear are free
	AST_CLEAR_FILE_REG_OP_WORD: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE1
		s_clear_file_reg_op_word |=> file_wr_en_out && zero_flag_set_out && !acc_wr_en_out)
		else $error("file clear word not executed");
	AST_CLEAR_ACCUMULATOR_OP_WORD: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE6
		s_clear_accumulator_op_word |=> acc_wr_en_out && zero_flag_set_out && !file_wr_en_out)
		else $error("accumulator clear word not executed");
	AST_CLEAR_FILE_REG_OP_STEP: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE7
		s_clear_file_reg_op_word |=> instr_ready_out && pc_out == $past(pc_out) + 13'h0001)
		else $error("file clear word took more than one cycle");
	AST_CLEAR_ACCUMULATOR_OP_STEP: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE7
		s_clear_accumulator_op_word |=> instr_ready_out && pc_out == $past(pc_out) + 13'h0001)
		else $error("accumulator clear word took more than one cycle");
	AST_CALL_WORD: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE2
		s_call_word |=> stack_push_out && stack_top_entry_out == $past(pc_out) + 13'h0001)
		else $error("call word pushed wrong return address");
	AST_CALL_TARGET: assert property (@(posedge core_clk_in) disable iff (!rst_b_in) // RULE3
		s_call_word |=> pc_out == {$past(program_counter_high_latch_in[4:3]),
			$past(instr_in[10:0])})
		else $error("call word loaded wrong target");
endmodule : ccie_exec

// [tb/ccie_exec_test.sv]
`timescale 1ns/1ps
module ccie_exec_test
	import ccie_pkg::*;
;
	logic core_clk_in, rst_b_in, instr_valid_in;
	logic [13:0] instr_in;
	logic [7:0] program_counter_high_latch_in, file_wr_data_out, acc_wr_data_out;
	logic instr_ready_out, file_wr_en_out, acc_wr_en_out, zero_flag_set_out, stack_push_out;
	logic flush_out;
	logic [12:0] pc_out, stack_top_entry_out, e_pc, e_tos;
	logic [6:0] file_wr_addr_out, e_fa;
	logic [15:0] rnd;
	int error_cnt, num_checks;
	int push_seen;
	logic [12:0] ret_q[$];
	ccie_exec uut (.core_clk_in, .rst_b_in, .instr_valid_in, .instr_in,
		.program_counter_high_latch_in, .instr_ready_out, .pc_out, .file_wr_en_out,
		.file_wr_addr_out, .file_wr_data_out, .acc_wr_en_out, .acc_wr_data_out,
		.zero_flag_set_out, .stack_push_out, .stack_top_entry_out, .flush_out);
	initial
	begin
		core_clk_in = 1'b0;
		forever #20 core_clk_in = ~core_clk_in;
	end
	// counts push pulses as the stack would see them, mid-cycle where settled
	always @(negedge core_clk_in)
		if (stack_push_out === 1'b1)
			push_seen++;
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// flags: file write, acc write, zero set, push, flush, ready
	function automatic logic [63:0] ev(input logic [5:0] fl);
		return {9'h0, fl, e_fa, 8'h00, 8'h00, e_pc, e_tos};
	endfunction : ev
	task automatic chk(input logic [63:0] exp);
		logic [63:0] got;
		got = {9'h0, file_wr_en_out, acc_wr_en_out, zero_flag_set_out, stack_push_out,
			flush_out, instr_ready_out, file_wr_addr_out, file_wr_data_out,
			acc_wr_data_out, pc_out, stack_top_entry_out};
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// drives at +2 ns, returns 1 ns after the taking edge
	task automatic step(input logic v, input logic [13:0] w);
		instr_valid_in = v;
		instr_in = w;
		@(posedge core_clk_in);
		#1;
	endtask : step
	task automatic do_call(input logic [10:0] k);
		ret_q.push_back(e_pc + 13'h1);
		e_tos = ret_q[$];
		e_pc = {program_counter_high_latch_in[4:3], k};
		step(1'b1, {3'h4, k});
		chk(ev(6'b000110));
		#1;
		// a non-clear word (bits 13:8 zero) offered in the second cycle must be ignored
		step(1'b1, 14'h0080);
		chk(ev(6'b000001));
		#1;
	endtask : do_call
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	initial
	begin
		repeat (5000) @(posedge core_clk_in);
		error_cnt++;
		results();
	end
	initial
	begin
		{rst_b_in, instr_valid_in, instr_in, program_counter_high_latch_in} = '0;
		{e_pc, e_tos, e_fa} = '0;
		rnd = 16'h003a;
		repeat (6) @(posedge core_clk_in);
		#1;
		chk(ev(6'b000001));
		#1;
		rst_b_in = 1'b1;
		$display("test reset done");
		program_counter_high_latch_in = 8'h18;
		do_call(11'h7ff);
		program_counter_high_latch_in = 8'he7;
		do_call(11'h000);
		$display("test call bounds done");
		repeat (200)
		begin
			rnd = lfsr(rnd);
			program_counter_high_latch_in = rnd[15:8];
			case (rnd[1:0])
				2'd0:
				begin
					e_fa = rnd[8:2];
					e_pc = e_pc + 13'h1;
					step(1'b1, {6'h01, 1'b1, rnd[8:2]});
					chk(ev(6'b101001));
					#1;
				end
				2'd1:
				begin
					e_pc = e_pc + 13'h1;
					step(1'b1, {6'h01, 1'b0, rnd[15:9]});
					chk(ev(6'b011001));
					#1;
				end
				2'd2: do_call({rnd[4:2], rnd[15:8]});
				default:
				begin
					e_pc = e_pc + {12'h0, rnd[2]};
					step(rnd[2], {2'b11, rnd[13:2]});
					chk(ev(6'b000001));
					#1;
				end
			endcase
		end
		num_checks++;
		if (push_seen != ret_q.size())
		begin
			error_cnt++;
			$display("unexpected at %0t got %h exp %h", $time, push_seen, ret_q.size());
		end
		$display("test random mix done");
		results();
	end
endmodule : ccie_exec_test
